// ==== rtl/dcpwm_pkg.sv ====
// Constants for the two-channel pulse modulator: register map and fields.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
package dcpwm_pkg;
    // Printed offsets are not multiples of four, so they are word indices.
    localparam logic [7:0] DCPWM_IDX_A_CTRL  = 8'h8a;
    localparam logic [7:0] DCPWM_IDX_A_DUTY  = 8'h8b;
    localparam logic [7:0] DCPWM_IDX_B_CTRL  = 8'h8c;
    localparam logic [7:0] DCPWM_IDX_B_DUTY  = 8'h8d;
    localparam logic [7:0] DCPWM_IDX_STATUS  = 8'h8f;
    localparam logic [7:0] DCPWM_IDX_SLEEP   = 8'h90;
    localparam int         DCPWM_ADDR_W      = 12;
    localparam logic [7:0] DCPWM_RESET_VAL   = 8'h00;
    localparam logic [7:0] DCPWM_CTRL_WMASK  = 8'hdf;
    localparam int         DCPWM_BIT_EN      = 7;
    localparam int         DCPWM_BIT_IDLE    = 6;
    localparam int         DCPWM_BIT_FSEL    = 4;
    localparam int         DCPWM_FIX_DIV_LOG = 4;
    localparam int         DCPWM_A_DIV_MAX   = 15;
    localparam int         DCPWM_B_DIV_MAX   = 7;
    localparam logic [1:0] DCPWM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DCPWM_RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/dcpwm_channel.sv ====
// One pulse channel: prescaler, 256-step counter and output selection.
// Assumes control and duty come from registers on the same clock.
`timescale 1ns/1ps
module dcpwm_channel
    import dcpwm_pkg::*;
#(
    parameter int DIV_MAX = 15
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Settings
    input  wire logic [7:0] control,
    input  wire logic [7:0] duty,
    input  wire logic       sleep,
    // Output
    output logic            pulse_out
);
    logic [14:0] pre_r;
    logic [7:0]  cnt_r;
    logic [7:0]  duty_r;
    logic        out_r;
    logic [3:0]  code;
    logic        tick;
    logic        out_nxt;
    logic        fixed_clk;

    // Codes above the documented range are clamped to the slowest rate.
    assign code = (int'(control[3:0]) > DIV_MAX) ?
                  4'(DIV_MAX) : control[3:0];
    // Tick once every 2**code clocks.
    assign tick = ((pre_r & ((15'h0001 << code) - 15'h0001)) == 15'h0000);
    assign fixed_clk = pre_r[DCPWM_FIX_DIV_LOG-1];

    // Output priority: fixed clock, then sleep or disable level, then duty.
    assign out_nxt = control[DCPWM_BIT_FSEL] ? fixed_clk :
        (sleep || !control[DCPWM_BIT_EN]) ?
            control[DCPWM_BIT_IDLE] :
        (cnt_r <= duty_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r  <= 15'h0000;
            cnt_r  <= 8'h00;
            duty_r <= DCPWM_RESET_VAL;
            out_r  <= 1'b0;
        end else begin
            pre_r <= pre_r + 15'h0001;
            out_r <= out_nxt;
            if (tick) begin
                cnt_r <= cnt_r + 8'h01;
                // Latching at the wrap avoids glitched periods on updates.
                if (cnt_r == 8'hff) begin
                    duty_r <= duty;
                end
            end
        end
    end

    assign pulse_out = out_r;
endmodule // dcpwm_channel

// ==== rtl/dcpwm_top.sv ====
// Top of the two-channel pulse modulator with its AXI4-Lite register file.
// Assumes one clock; pins drive an external load such as a backlight.
//
// Summary of operation
// - Channel A high time is (N+1)/256.
// - Channel B bit 7 enables, else idle level.
// - Channel B bit 6 sets idle or sleep level.
// - Idle level applies only while bit 4 clear.
// - Channel B codes 0-7 divide by 2**code.
// - Channel B high time is (N+1)/256.
// - Channel A bit 7 enables, bit 6 idles.
// - Channel A bit 4 outputs clock divided sixteen.
// - Channel A codes 0-15 divide by 2**code.
`timescale 1ns/1ps
module dcpwm_top
    import dcpwm_pkg::*;
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic [DCPWM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [DCPWM_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Pulse outputs
    output logic                         pulse_a_output,
    output logic                         pulse_b_output
);
    logic [7:0]              pulse_a_control_r;
    logic [7:0]              pulse_a_duty_r;
    logic [7:0]              pulse_b_control_r;
    logic [7:0]              pulse_b_duty_r;
    logic                    sleep_r;
    logic                    aw_got_r;
    logic                    w_got_r;
    logic [DCPWM_ADDR_W-1:0] awaddr_r;
    logic [7:0]              wdata_r;
    logic                    wstrb0_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic                    rvalid_r;
    logic [1:0]              rresp_r;
    logic [31:0]             rdata_r;

    // Byte address to word index; low two bits ignored.
    function automatic logic [9:0] word_idx(
        input logic [DCPWM_ADDR_W-1:0] a);
        word_idx = a[DCPWM_ADDR_W-1:2];
    endfunction

    function automatic logic mapped(input logic [9:0] i);
        mapped = (i == 10'(DCPWM_IDX_A_CTRL)) || (i == 10'(DCPWM_IDX_A_DUTY))
              || (i == 10'(DCPWM_IDX_B_CTRL)) || (i == 10'(DCPWM_IDX_B_DUTY))
              || (i == 10'(DCPWM_IDX_STATUS)) || (i == 10'(DCPWM_IDX_SLEEP));
    endfunction

    wire       aw_hs   = s_axi_awvalid && s_axi_awready;
    wire       w_hs    = s_axi_wvalid && s_axi_wready;
    wire       wr_go   = aw_got_r && w_got_r && !bvalid_r;
    wire [9:0] w_idx   = word_idx(awaddr_r);
    wire       w_en    = wr_go && wstrb0_r;
    wire       ar_hs   = s_axi_arvalid && s_axi_arready;
    wire [9:0] r_idx   = word_idx(s_axi_araddr);
    wire [7:0] status  = {6'h00, pulse_b_output, pulse_a_output};
    wire [7:0] rd_byte =
        (r_idx == 10'(DCPWM_IDX_A_CTRL)) ? pulse_a_control_r :
        (r_idx == 10'(DCPWM_IDX_A_DUTY)) ? pulse_a_duty_r :
        (r_idx == 10'(DCPWM_IDX_B_CTRL)) ? pulse_b_control_r :
        (r_idx == 10'(DCPWM_IDX_B_DUTY)) ? pulse_b_duty_r :
        (r_idx == 10'(DCPWM_IDX_STATUS)) ? status :
        (r_idx == 10'(DCPWM_IDX_SLEEP))  ? {7'h00, sleep_r} : 8'h00;

    // Readies stay low while a response waits, so one write is open at once.
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // Address and data may come in either order; each is held until used.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
        end else if (aw_hs) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r  <= 1'b0;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
        end else if (w_hs) begin
            w_got_r  <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_got_r <= 1'b0;
        end
    end

    // The response rises once both halves are held; setting wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= DCPWM_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= mapped(w_idx) ? DCPWM_RESP_OKAY
                                      : DCPWM_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    wire we_a_ctrl = w_en && (w_idx == 10'(DCPWM_IDX_A_CTRL));
    wire we_a_duty = w_en && (w_idx == 10'(DCPWM_IDX_A_DUTY));
    wire we_b_ctrl = w_en && (w_idx == 10'(DCPWM_IDX_B_CTRL));
    wire we_b_duty = w_en && (w_idx == 10'(DCPWM_IDX_B_DUTY));
    wire we_sleep  = w_en && (w_idx == 10'(DCPWM_IDX_SLEEP));

    // Registers reset to zero; reserved bit 5 of each control reads zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_a_control_r <= DCPWM_RESET_VAL;
        end else if (we_a_ctrl) begin
            pulse_a_control_r <= wdata_r & DCPWM_CTRL_WMASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_a_duty_r <= DCPWM_RESET_VAL;
        end else if (we_a_duty) begin
            pulse_a_duty_r <= wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_b_control_r <= DCPWM_RESET_VAL;
        end else if (we_b_ctrl) begin
            pulse_b_control_r <= wdata_r & DCPWM_CTRL_WMASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_b_duty_r <= DCPWM_RESET_VAL;
        end else if (we_b_duty) begin
            pulse_b_duty_r <= wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_r <= 1'b0;
        end else if (we_sleep) begin
            sleep_r <= wdata_r[0];
        end
    end

    // Read channel; data is held until rready.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= DCPWM_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rresp_r  <= mapped(r_idx) ? DCPWM_RESP_OKAY : DCPWM_RESP_SLVERR;
            rdata_r  <= {24'h000000, rd_byte};
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // The fixed-clock mode of channel A uses the system clock, since the
    // oscillator is not a separate clock here.
    dcpwm_channel #(.DIV_MAX(DCPWM_A_DIV_MAX)) u_chan_a (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .control   (pulse_a_control_r),
        .duty      (pulse_a_duty_r),
        .sleep     (sleep_r),
        .pulse_out (pulse_a_output)
    );

    dcpwm_channel #(.DIV_MAX(DCPWM_B_DIV_MAX)) u_chan_b (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .control   (pulse_b_control_r),
        .duty      (pulse_b_duty_r),
        .sleep     (sleep_r),
        .pulse_out (pulse_b_output)
    );
endmodule // dcpwm_top

// ==== dv/dcpwm_load.sv ====
// Load on one pulse pin: measures high time and period per pulse.
// Assumes the pin is sampled on the system clock.
`timescale 1ns/1ps
module dcpwm_load (
    // Clock and pin
    input wire logic aclk,
    input wire logic pin,
    // Last whole pulse seen
    output int       hi_len,
    output int       per_len,
    output int       n_rise
);
    int  hc_r;
    int  pc_r;
    bit  last_r;
    wire rise = pin && !last_r;
    // A period is only known at the next rising edge, so values lag one.
    always @(posedge aclk) begin
        last_r <= pin;
        hc_r   <= rise ? 1 : hc_r + int'(pin);
        pc_r   <= rise ? 1 : pc_r + 1;
        if (rise) begin
            hi_len  <= hc_r;
            per_len <= pc_r;
            n_rise  <= n_rise + 1;
        end
    end
endmodule // dcpwm_load

// ==== dv/dcpwm_chk.sv ====
// Checker on the modulator top ports: bus handshakes and reset levels.
// Assumes it is bound into the top and sees its ports by name.
`timescale 1ns/1ps
module dcpwm_chk
    import dcpwm_pkg::*;
(
    // Clock and bus
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins
    input wire logic        pulse_a_output,
    input wire logic        pulse_b_output
);
    default clocking dck @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_arr; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arr: assert property (p_arr) else $error("read taken while busy");
    property p_awr; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awr: assert property (p_awr) else $error("write taken while busy");
    property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rhi: assert property (p_rhi) else $error("read upper bits set");
    property p_rst; $rose(aresetn) |-> !pulse_a_output && !pulse_b_output
        && !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_rst: assert property (p_rst) else $error("reset level wrong");
endmodule // dcpwm_chk

// ==== dv/tb_top.sv ====
// Bench for the modulator: register tasks, pin checks, final verdict.
// Assumes a 250 MHz clock and one load model on each pulse pin.
`timescale 1ns/1ps
module tb_top;
    import dcpwm_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        pulse_a_output, pulse_b_output;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_fail = 0, check_count = 0, ha, pa, ea, hb, pb, eb;
    dcpwm_top dcpwm_top_i (.*);
    dcpwm_load dcpwm_load_i (.aclk, .pin(pulse_a_output), .hi_len(ha),
                             .per_len(pa), .n_rise(ea));
    dcpwm_load dcpwm_load_b_i (.aclk, .pin(pulse_b_output), .hi_len(hb),
                               .per_len(pb), .n_rise(eb));
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = s_axi_arready;
            1: pick = s_axi_bvalid;
            default: pick = s_axi_rvalid;
        endcase
    endfunction
    // Sampled at the falling edge, where the answer has settled, so the
    // handshake completes at the rising edge that follows.
    task automatic wait_hi(input int k);
        for (int i = 0; i < 64; i++) begin
            @(negedge aclk);
            if (pick(k) === 1'h1) begin
                @(posedge aclk);
                return;
            end
        end
        $display("CHECK FAILED at %0t: no answer", $time);
        n_fail++;
        complete_run();
    endtask
    // Ready is raised late on purpose so that held answers get exercised.
    task automatic wr(input logic [7:0] ix, d, input logic [1:0] rsp);
        bit a_done, w_done, a_now, w_now;
        a_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr  <= {2'h0, ix, 2'h0};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        for (int i = 0; i < 64 && !(a_done && w_done); i++) begin
            @(negedge aclk);
            a_now = !a_done && s_axi_awready === 1'h1;
            w_now = !w_done && s_axi_wready === 1'h1;
            @(posedge aclk);
            if (a_now) begin
                s_axi_awvalid <= 1'h0;
                a_done = 1'b1;
            end
            if (w_now) begin
                s_axi_wvalid <= 1'h0;
                w_done = 1'b1;
            end
        end
        if (!(a_done && w_done)) begin
            $display("CHECK FAILED at %0t: write not taken", $time);
            n_fail++;
            complete_run();
        end
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'h1;
        wait_hi(1);
        chk({30'h0, s_axi_bresp}, {30'h0, rsp});
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] ix, d, input logic [1:0] rsp);
        s_axi_araddr  <= {2'h0, ix, 2'h0};
        s_axi_arvalid <= 1'h1;
        wait_hi(0);
        s_axi_arvalid <= 1'h0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'h1;
        wait_hi(2);
        chk(s_axi_rdata, {24'h000000, d});
        chk({30'h0, s_axi_rresp}, {30'h0, rsp});
        s_axi_rready <= 1'h0;
    endtask
    // Three rises are awaited so the measured period is wholly new.
    task automatic meas(input bit b, input int hi, input int per);
        int e;
        e = b ? eb : ea;
        for (int i = 0; i < 8000 && (b ? eb : ea) < e + 3; i++)
            @(posedge aclk);
        if ((b ? eb : ea) < e + 3) begin
            $display("CHECK FAILED at %0t: no pulses", $time);
            n_fail++;
            complete_run();
        end
        chk(b ? hb : ha, hi);
        chk(b ? pb : pa, per);
    endtask
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++)
            rd(8'(DCPWM_IDX_A_CTRL + i), 8'h00, DCPWM_RESP_OKAY);
        rd(8'h00, 8'h00, DCPWM_RESP_SLVERR);
        wr(8'h00, 8'h5a, DCPWM_RESP_SLVERR);
        s_axi_wstrb <= 4'he;
        wr(DCPWM_IDX_A_DUTY, 8'h77, DCPWM_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(DCPWM_IDX_A_DUTY, 8'h00, DCPWM_RESP_OKAY);
        rd(DCPWM_IDX_STATUS, 8'h00, DCPWM_RESP_OKAY);
        rd(DCPWM_IDX_SLEEP, 8'h00, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_B_CTRL, 8'hff, DCPWM_RESP_OKAY);
        rd(DCPWM_IDX_B_CTRL, 8'hdf, DCPWM_RESP_OKAY);
        $display("test registers done");
        wr(DCPWM_IDX_B_CTRL, 8'h40, DCPWM_RESP_OKAY);
        chk({31'h0, pulse_b_output}, 32'h1);
        wr(DCPWM_IDX_A_CTRL, 8'h40, DCPWM_RESP_OKAY);
        chk({31'h0, pulse_a_output}, 32'h1);
        rd(DCPWM_IDX_STATUS, 8'h03, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_B_CTRL, 8'h50, DCPWM_RESP_OKAY);
        meas(1, 8, 16);
        wr(DCPWM_IDX_A_CTRL, 8'h50, DCPWM_RESP_OKAY);
        meas(0, 8, 16);
        $display("test idle and fixed clock done");
        wr(DCPWM_IDX_A_CTRL, 8'h80, DCPWM_RESP_OKAY);
        meas(0, 1, 256);
        wr(DCPWM_IDX_A_DUTY, 8'h10, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_A_CTRL, 8'h81, DCPWM_RESP_OKAY);
        meas(0, 34, 512);
        wr(DCPWM_IDX_B_DUTY, 8'hfe, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_B_CTRL, 8'h83, DCPWM_RESP_OKAY);
        meas(1, 2040, 2048);
        wr(DCPWM_IDX_A_DUTY, 8'hff, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_B_DUTY, 8'hff, DCPWM_RESP_OKAY);
        repeat (4200) @(posedge aclk);
        for (int i = 0; i < 3; i++) begin
            repeat (700) @(posedge aclk);
            chk({30'h0, pulse_b_output, pulse_a_output}, 32'h3);
        end
        wr(DCPWM_IDX_SLEEP, 8'h01, DCPWM_RESP_OKAY);
        chk({30'h0, pulse_b_output, pulse_a_output}, 32'h0);
        rd(DCPWM_IDX_SLEEP, 8'h01, DCPWM_RESP_OKAY);
        wr(DCPWM_IDX_SLEEP, 8'h00, DCPWM_RESP_OKAY);
        $display("test duty done");
        complete_run();
    end
endmodule // tb_top
bind dcpwm_top dcpwm_chk dcpwm_chk_i (.*);
